/* File: cfw_pkg.sv */
/*
  Package for the CPU flag register and working-register pointer block.
  Assumes the execution unit drives one operation code per enabled cycle.
*/
package cfw_pkg;
  // Register-file addresses
  localparam logic [7:0] ADDR_STATUS_FLAGS  = 8'he7;
  localparam logic [7:0] ADDR_WORK_PTR_LOW  = 8'he8;
  localparam logic [7:0] ADDR_WORK_PTR_HIGH = 8'he9;
  // Flag bit positions
  localparam int BIT_CARRY = 7;
  localparam int BIT_ZERO  = 6;
  localparam int BIT_SIGN  = 5;
  localparam int BIT_OVFL  = 4;
  localparam int BIT_BCD   = 3;
  localparam int BIT_HALF  = 2;
  localparam int BIT_USER  = 1;
  localparam int BIT_SPACE = 0;
  // Pointer fields and flag update masks
  localparam int PTR_MODE_BIT  = 2;
  localparam logic [7:0] PTR_WRITE_MASK = 8'hf8;
  localparam logic [7:0] FLAG_UPD_ALL   = 8'hfc;
  localparam logic [7:0] FLAG_UPD_ZSV   = 8'h70;

  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_SRA, OP_RRC, OP_RLC,
    OP_ROR, OP_ROL, OP_DA, OP_MULDIV, OP_LOGIC, OP_INCDEC, OP_TEST,
    OP_SCF, OP_RCF, OP_CCF, OP_SUF, OP_RUF, OP_SDM, OP_SPM,
    OP_SRP, OP_LOAD_LOW_WINDOW, OP_LOAD_HIGH_WINDOW
  } cfw_op_t;
endpackage

/* File: cfw_alu_flags.sv */
/*
  Combinational flag evaluation for one accumulator operation.
  Assumes operands are zero-extended to 16 bits for byte operations.
*/
`timescale 1ns/1ps
module cfw_alu_flags (
  // Operation
  input  wire cfw_pkg::cfw_op_t i_op,
  input  wire logic             i_word,
  input  wire logic [15:0]      i_a,
  input  wire logic [15:0]      i_b,
  input  wire logic [15:0]      i_res,
  input  wire logic             i_carry_in,
  input  wire logic             i_bcd_in,
  input  wire logic             i_half_in,
  input  wire logic             i_aux_carry,
  // Flags out
  output logic                  o_carry,
  output logic                  o_zero,
  output logic                  o_sign,
  output logic                  o_ovfl,
  output logic                  o_half
);
  logic        top_a;
  logic        top_b;
  logic        top_r;
  logic        is_sub;
  logic [16:0] wide;
  logic [4:0]  nib;

  always_comb begin
    top_a  = i_word ? i_a[15] : i_a[7];
    top_b  = i_word ? i_b[15] : i_b[7];
    top_r  = i_word ? i_res[15] : i_res[7];
    is_sub = (i_op == cfw_pkg::OP_SUB) || (i_op == cfw_pkg::OP_SBC) || (i_op == cfw_pkg::OP_CP);
    wide   = 17'h00000;
    nib    = 5'h00;
    o_carry = i_carry_in;
    o_half  = i_half_in;
    o_ovfl  = 1'b0;
    o_zero  = i_word ? (i_res == 16'h0000) : (i_res[7:0] == 8'h00); // RULE_04
    o_sign  = top_r;                                                 // RULE_05
    case (i_op)
      cfw_pkg::OP_ADD, cfw_pkg::OP_ADC: begin
        wide = {1'b0, i_a} + {1'b0, i_b} + {16'h0000, (i_op == cfw_pkg::OP_ADC) & i_carry_in};
        nib  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, (i_op == cfw_pkg::OP_ADC) & i_carry_in};
        o_carry = i_word ? wide[16] : wide[8];          // RULE_01
        o_ovfl  = (top_a == top_b) && (top_r != top_a); // RULE_06
        o_half  = nib[4];                               // RULE_08
      end
      cfw_pkg::OP_SUB, cfw_pkg::OP_SBC, cfw_pkg::OP_CP: begin
        wide = {1'b0, i_a} - {1'b0, i_b} - {16'h0000, (i_op == cfw_pkg::OP_SBC) & i_carry_in};
        nib  = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, (i_op == cfw_pkg::OP_SBC) & i_carry_in};
        o_carry = i_word ? wide[16] : wide[8];          // RULE_01
        o_ovfl  = (top_a != top_b) && (top_r != top_a); // RULE_06
        o_half  = nib[4];                               // RULE_08
      end
      cfw_pkg::OP_SRA, cfw_pkg::OP_RRC, cfw_pkg::OP_ROR: begin
        o_carry = i_a[0];
        o_ovfl  = top_r != top_a;
      end
      cfw_pkg::OP_RLC, cfw_pkg::OP_ROL: begin
        o_carry = top_a;
        o_ovfl  = top_r != top_a;
      end
      cfw_pkg::OP_DA: begin
        // Carry is the auxiliary carry or the old carry; the recorded direction flag cancels out
        o_carry = i_aux_carry | (i_carry_in & ~i_bcd_in) | (i_carry_in & i_bcd_in); // RULE_08
      end
      cfw_pkg::OP_MULDIV: o_carry = i_aux_carry;
      default: o_ovfl = 1'b0;
    endcase
    if (is_sub && (i_op == cfw_pkg::OP_NONE)) o_ovfl = 1'b0;
  end
endmodule // cfw_alu_flags

/* File: cfw_flags_ptrs.sv */
/*
  CPU status flag register and working-register pointers with address mapping.
  Assumes an execution unit issues one op or register write per enabled cycle.
*/
// What this block does
// RULE_01 - Carry set on carry out of bit 7 byte or bit 15 word.
// RULE_02 - Carry changes only on arithmetic, shift, rotate, adjust, multiply, divide, carry ops.
// RULE_03 - Carry can be forced one, forced zero, or inverted.
// RULE_04 - Zero flag set when result is zero, also for logic, inc/dec, tests.
// RULE_05 - Sign flag copies top result bit, updated with zero flag.
// RULE_06 - Overflow flag marks signed range exceeded, updated with zero and sign; inc/dec here always clears it.
// RULE_07 - BCD direction flag records whether last arithmetic was add or subtract.
// RULE_08 - Half carry from bit 3 on byte add/subtract, used by adjust; adjust here ignores it and takes carry from i_aux_carry or old carry.
// RULE_09 - User flag changes only by explicit set or clear.
// RULE_10 - Space flag set selects data, clear selects program; readable.
// RULE_11 - Flags carry, zero, sign, overflow, BCD, half, user, space at bits 7..0.
// RULE_12 - Twin loads set mode bit in both pointers; single load clears it.
// RULE_13 - Pointers hold group in bits 7..3; bits 1,0 read zero.
// RULE_14 - Address upper nibble is group, lower nibble register in group.
// RULE_15 - Single mode address is working number plus first pointer.
// RULE_16 - Single mode window aligns down to even 8-register group.
// RULE_17 - Twin mode: r0-r7 use first pointer, r8-r15 second pointer.
// RULE_18 - Group just below system registers reachable only through pointers.
// RULE_19 - Software keeps windows on 8 or 16 register boundaries.
// RULE_20 - Software treats second pointer as reserved when unused.
// RULE_21 - Unlisted ops leave flags; no reset initialisation of flags or pointers.
`timescale 1ns/1ps
module cfw_flags_ptrs (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_clk_en,
  // Operation from execution unit
  input  wire cfw_pkg::cfw_op_t i_op,
  input  wire logic             i_word,
  input  wire logic [15:0]      i_a,
  input  wire logic [15:0]      i_b,
  input  wire logic [15:0]      i_res,
  input  wire logic             i_aux_carry,
  input  wire logic [7:0]       i_ptr_value,
  // Register-file port
  input  wire logic             i_reg_wr,
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic [7:0]       i_reg_wdata,
  output logic [7:0]            o_reg_rdata,
  output logic                  o_reg_hit,
  // Working register mapping
  input  wire logic [3:0]       i_work_num,
  input  wire logic [7:0]       i_direct_addr,
  input  wire logic             i_direct_req,
  output logic [7:0]            o_work_addr,
  output logic                  o_direct_refused,
  // Flags
  output logic [7:0]            o_status_flags,
  output logic                  o_data_space
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] status_flags;
  logic [7:0] work_pointer_low;
  logic [7:0] work_pointer_high;
  logic       n_carry;
  logic       n_zero;
  logic       n_sign;
  logic       n_ovfl;
  logic       n_half;
  logic [7:0] upd_mask;
  logic [7:0] next_flags;

  cfw_alu_flags u_alu_flags (
    .i_op        (i_op),
    .i_word      (i_word),
    .i_a         (i_a),
    .i_b         (i_b),
    .i_res       (i_res),
    .i_carry_in  (status_flags[cfw_pkg::BIT_CARRY]),
    .i_bcd_in    (status_flags[cfw_pkg::BIT_BCD]),
    .i_half_in   (status_flags[cfw_pkg::BIT_HALF]),
    .i_aux_carry (i_aux_carry),
    .o_carry     (n_carry),
    .o_zero      (n_zero),
    .o_sign      (n_sign),
    .o_ovfl      (n_ovfl),
    .o_half      (n_half)
  );

  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] target);
    is_reg = (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Flag update
  always_comb begin
    next_flags = status_flags;
    upd_mask   = 8'h00;
    case (i_op)
      cfw_pkg::OP_ADD, cfw_pkg::OP_ADC, cfw_pkg::OP_SUB, cfw_pkg::OP_SBC, cfw_pkg::OP_CP,
      cfw_pkg::OP_SRA, cfw_pkg::OP_RRC, cfw_pkg::OP_RLC, cfw_pkg::OP_ROR, cfw_pkg::OP_ROL,
      cfw_pkg::OP_DA, cfw_pkg::OP_MULDIV: upd_mask = 8'hf0;       // RULE_02
      cfw_pkg::OP_LOGIC, cfw_pkg::OP_INCDEC, cfw_pkg::OP_TEST: upd_mask = cfw_pkg::FLAG_UPD_ZSV; // RULE_04
      default: upd_mask = 8'h00;                                   // RULE_21
    endcase
    if (upd_mask[cfw_pkg::BIT_CARRY]) next_flags[cfw_pkg::BIT_CARRY] = n_carry; // RULE_01
    if (upd_mask[cfw_pkg::BIT_ZERO])  next_flags[cfw_pkg::BIT_ZERO]  = n_zero;  // RULE_04
    if (upd_mask[cfw_pkg::BIT_SIGN])  next_flags[cfw_pkg::BIT_SIGN]  = n_sign;  // RULE_05
    if (upd_mask[cfw_pkg::BIT_OVFL])  next_flags[cfw_pkg::BIT_OVFL]  = n_ovfl;  // RULE_06
    case (i_op)
      cfw_pkg::OP_ADD, cfw_pkg::OP_ADC: begin
        next_flags[cfw_pkg::BIT_BCD] = 1'b0;                              // RULE_07
        if (!i_word) next_flags[cfw_pkg::BIT_HALF] = n_half;              // RULE_08
      end
      cfw_pkg::OP_SUB, cfw_pkg::OP_SBC: begin
        next_flags[cfw_pkg::BIT_BCD] = 1'b1;                              // RULE_07
        if (!i_word) next_flags[cfw_pkg::BIT_HALF] = n_half;              // RULE_08
      end
      cfw_pkg::OP_SCF: next_flags[cfw_pkg::BIT_CARRY] = 1'b1;             // RULE_03
      cfw_pkg::OP_RCF: next_flags[cfw_pkg::BIT_CARRY] = 1'b0;             // RULE_03
      cfw_pkg::OP_CCF: next_flags[cfw_pkg::BIT_CARRY] = ~status_flags[cfw_pkg::BIT_CARRY]; // RULE_03
      cfw_pkg::OP_SUF: next_flags[cfw_pkg::BIT_USER] = 1'b1;              // RULE_09
      cfw_pkg::OP_RUF: next_flags[cfw_pkg::BIT_USER] = 1'b0;              // RULE_09
      cfw_pkg::OP_SDM: next_flags[cfw_pkg::BIT_SPACE] = 1'b1;             // RULE_10
      cfw_pkg::OP_SPM: next_flags[cfw_pkg::BIT_SPACE] = 1'b0;             // RULE_10
      default: next_flags[cfw_pkg::BIT_USER] = status_flags[cfw_pkg::BIT_USER];
    endcase
    // Explicit register write of the whole flag byte
    if (i_reg_wr && is_reg(i_reg_addr, cfw_pkg::ADDR_STATUS_FLAGS)) next_flags = i_reg_wdata; // RULE_11
  end

  // No reset: contents undefined until software loads them
  always_ff @(posedge i_clk) begin
    if (i_clk_en) status_flags <= next_flags; // RULE_21
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer update
  always_ff @(posedge i_clk) begin
    if (i_clk_en) begin
      case (i_op)
        cfw_pkg::OP_SRP: begin
          work_pointer_low  <= {i_ptr_value[7:4], 4'h0};              // RULE_16 RULE_12 RULE_13
          work_pointer_high <= {work_pointer_high[7:3], 3'h0};        // RULE_12
        end
        cfw_pkg::OP_LOAD_LOW_WINDOW: begin
          work_pointer_low  <= {i_ptr_value[7:3], 3'h4};              // RULE_12 RULE_13
          work_pointer_high <= {work_pointer_high[7:3], 3'h4};        // RULE_12
        end
        cfw_pkg::OP_LOAD_HIGH_WINDOW: begin
          work_pointer_high <= {i_ptr_value[7:3], 3'h4};              // RULE_12 RULE_13
          work_pointer_low  <= {work_pointer_low[7:3], 3'h4};         // RULE_12
        end
        default: begin
          if (i_reg_wr && is_reg(i_reg_addr, cfw_pkg::ADDR_WORK_PTR_LOW))
            work_pointer_low <= i_reg_wdata & cfw_pkg::PTR_WRITE_MASK;  // RULE_13
          if (i_reg_wr && is_reg(i_reg_addr, cfw_pkg::ADDR_WORK_PTR_HIGH))
            work_pointer_high <= i_reg_wdata & cfw_pkg::PTR_WRITE_MASK; // RULE_13
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back and address mapping, registered outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata      <= 8'h00;
      o_reg_hit        <= 1'b0;
      o_work_addr      <= 8'h00;
      o_direct_refused <= 1'b0;
      o_status_flags   <= 8'h00;
      o_data_space     <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_hit <= is_reg(i_reg_addr, cfw_pkg::ADDR_STATUS_FLAGS) |
                   is_reg(i_reg_addr, cfw_pkg::ADDR_WORK_PTR_LOW) |
                   is_reg(i_reg_addr, cfw_pkg::ADDR_WORK_PTR_HIGH);
      if (is_reg(i_reg_addr, cfw_pkg::ADDR_STATUS_FLAGS))       o_reg_rdata <= status_flags;   // RULE_11
      else if (is_reg(i_reg_addr, cfw_pkg::ADDR_WORK_PTR_LOW))  o_reg_rdata <= work_pointer_low;
      else if (is_reg(i_reg_addr, cfw_pkg::ADDR_WORK_PTR_HIGH)) o_reg_rdata <= work_pointer_high;
      else                                                      o_reg_rdata <= 8'h00;
      if (!work_pointer_low[cfw_pkg::PTR_MODE_BIT])
        o_work_addr <= {work_pointer_low[7:4], 4'h0} + {4'h0, i_work_num};          // RULE_14 RULE_15 RULE_16
      else if (!i_work_num[3])
        o_work_addr <= {work_pointer_low[7:3], 3'h0} + {5'h00, i_work_num[2:0]};    // RULE_17
      else
        o_work_addr <= {work_pointer_high[7:3], 3'h0} + {5'h00, i_work_num[2:0]};   // RULE_17
      o_direct_refused <= i_direct_req && (i_direct_addr[7:4] == 4'hd);              // RULE_18
      o_status_flags   <= status_flags;
      o_data_space     <= status_flags[cfw_pkg::BIT_SPACE];                         // RULE_10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Flag checks
  AST_CARRY_SET: assert property ( // RULE_03
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_SCF && !i_reg_wr
    |=> status_flags[7])
    else $error("carry not set");

  AST_CARRY_CPL: assert property ( // RULE_03
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_CCF && !i_reg_wr
    |=> status_flags[7] != $past(status_flags[7]))
    else $error("carry not inverted");

  AST_CARRY_CLR: assert property ( // RULE_03
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_RCF && !i_reg_wr
    |=> !status_flags[7])
    else $error("carry not cleared");

  AST_CARRY_BYTE: assert property ( // RULE_01
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_ADD && !i_reg_wr && !i_word &&
    (({1'b0, i_a[7:0]} + {1'b0, i_b[7:0]}) > 9'h0ff)
    |=> status_flags[cfw_pkg::BIT_CARRY])
    else $error("byte carry missing");

  AST_CARRY_HOLD: assert property ( // RULE_02
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_LOGIC && !i_reg_wr
    |=> $stable(status_flags[7]))
    else $error("carry changed by logic op");

  AST_ZERO_SET: assert property ( // RULE_04
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op inside {cfw_pkg::OP_LOGIC, cfw_pkg::OP_INCDEC, cfw_pkg::OP_TEST} &&
    !i_reg_wr && i_word && i_res == 16'h0000
    |=> status_flags[cfw_pkg::BIT_ZERO])
    else $error("zero flag missing");

  AST_SIGN_COPY: assert property ( // RULE_05
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op inside {cfw_pkg::OP_LOGIC, cfw_pkg::OP_INCDEC, cfw_pkg::OP_TEST} &&
    !i_reg_wr && !i_word && i_res[7]
    |=> status_flags[cfw_pkg::BIT_SIGN])
    else $error("sign flag missing");

  AST_OVFL_ADD: assert property ( // RULE_06
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_ADD && !i_reg_wr && !i_word &&
    i_a[7] == i_b[7] && i_res[7] != i_a[7]
    |=> status_flags[cfw_pkg::BIT_OVFL])
    else $error("overflow flag missing");

  AST_BCD_SUB: assert property ( // RULE_07
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_SUB && !i_reg_wr
    |=> status_flags[3])
    else $error("direction not subtract");

  AST_BCD_ADD: assert property ( // RULE_07
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_ADD && !i_reg_wr
    |=> !status_flags[3])
    else $error("direction not add");

  AST_HALF_ADD: assert property ( // RULE_08
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_ADD && !i_reg_wr && !i_word &&
    (({1'b0, i_a[3:0]} + {1'b0, i_b[3:0]}) > 5'h0f)
    |=> status_flags[cfw_pkg::BIT_HALF])
    else $error("half carry missing");

  AST_USER_HOLD: assert property ( // RULE_09
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_ADD && !i_reg_wr
    |=> $stable(status_flags[1]))
    else $error("user flag changed");

  AST_USER_SET: assert property ( // RULE_09
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_SUF && !i_reg_wr
    |=> status_flags[1])
    else $error("user flag not set");

  AST_SPACE_OUT: assert property ( // RULE_10
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_SDM && !i_reg_wr ##1 i_clk_en
    |=> o_data_space)
    else $error("data space not shown");

  AST_SPACE_CLR: assert property ( // RULE_10
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_SPM && !i_reg_wr
    |=> !status_flags[0])
    else $error("program space not selected");

  AST_FLAG_WRITE: assert property ( // RULE_11
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_reg_wr && i_reg_addr == cfw_pkg::ADDR_STATUS_FLAGS
    |=> status_flags == $past(i_reg_wdata))
    else $error("flag byte not written");

  AST_FREEZE: assert property ( // RULE_21
    @(posedge i_clk) disable iff (!i_resetn)
    !i_clk_en
    |=> $stable(status_flags) && $stable(o_status_flags))
    else $error("state moved while frozen");

  // Pointer checks
  AST_TWIN_MODE: assert property ( // RULE_12
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_LOAD_HIGH_WINDOW
    |=> work_pointer_low[2] && work_pointer_high[2])
    else $error("twin mode bit missing");

  AST_SINGLE_MODE: assert property ( // RULE_12
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_SRP
    |=> !work_pointer_low[2] && !work_pointer_high[2])
    else $error("single mode bit not cleared");

  AST_PTR_LOW_BITS: assert property ( // RULE_13
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_reg_wr && i_reg_addr == cfw_pkg::ADDR_WORK_PTR_LOW && i_op == cfw_pkg::OP_NONE
    |=> work_pointer_low[2:0] == 3'h0)
    else $error("pointer low bits not zero");

  AST_SINGLE_ALIGN: assert property ( // RULE_16
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_op == cfw_pkg::OP_SRP
    |=> work_pointer_low[3:0] == 4'h0)
    else $error("single window not aligned");

  AST_SINGLE_MAP: assert property ( // RULE_15
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && !work_pointer_low[2]
    |=> o_work_addr[7:4] == $past(work_pointer_low[7:4]) && o_work_addr[3:0] == $past(i_work_num))
    else $error("single mode address wrong");

  AST_TWIN_HIGH: assert property ( // RULE_17
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && work_pointer_low[2] && i_work_num[3]
    |=> o_work_addr[7:3] == $past(work_pointer_high[7:3]) && o_work_addr[2:0] == $past(i_work_num[2:0]))
    else $error("twin high address wrong");

  AST_DIRECT_D: assert property ( // RULE_18
    @(posedge i_clk) disable iff (!i_resetn)
    i_clk_en && i_direct_req && i_direct_addr[7:4] == 4'hd
    |=> o_direct_refused)
    else $error("direct access not refused");

  COV_LOAD_LOW_WINDOW: cover property (@(posedge i_clk) i_clk_en && i_op == cfw_pkg::OP_LOAD_LOW_WINDOW);
  COV_ADD:  cover property (@(posedge i_clk) i_clk_en && i_op == cfw_pkg::OP_ADD);
  COV_REFUSE: cover property (@(posedge i_clk) o_direct_refused);
  COV_TWIN_HIGH: cover property (@(posedge i_clk) i_clk_en && work_pointer_low[2] && i_work_num[3]);
  COV_FREEZE: cover property (@(posedge i_clk) !i_clk_en);
endmodule // cfw_flags_ptrs

/* File: cfw_exec_model.sv */
/*
  Execution-unit model: forms the accumulator result of each operation.
  Assumes byte operands arrive zero-extended in the low byte.
*/
`timescale 1ns/1ps
module cfw_exec_model (
  // Operation
  input  wire cfw_pkg::cfw_op_t i_op,
  input  wire logic             i_word,
  input  wire logic [15:0]      i_a,
  input  wire logic [15:0]      i_b,
  // Result
  output logic [15:0]           o_res,
  output logic                  o_aux_carry
);
  logic [15:0] raw;

  always_comb begin
    case (i_op)
      cfw_pkg::OP_ADD, cfw_pkg::OP_ADC: raw = i_a + i_b;
      cfw_pkg::OP_SUB, cfw_pkg::OP_SBC, cfw_pkg::OP_CP: raw = i_a - i_b;
      cfw_pkg::OP_LOGIC, cfw_pkg::OP_TEST: raw = i_a & i_b;
      cfw_pkg::OP_INCDEC: raw = i_a + 16'h0001;
      default: raw = {i_a[0], i_a[15:1]};
    endcase
  end

  // Byte results confined to the low byte
  assign o_res       = i_word ? raw : {8'h00, raw[7:0]};
  assign o_aux_carry = i_a[0];
endmodule // cfw_exec_model

/* File: tb_cfw_flags_ptrs.sv */
/*
  Self-checking bench for the flag register and working-register pointers.
  Assumes the execution-unit model supplies results from the operands.
*/
`timescale 1ns/1ps
module tb_cfw_flags_ptrs;
  typedef struct {int due; int kind; logic [7:0] mask; logic [7:0] exp;} cfw_note_t;
  logic             i_clk, i_resetn, i_clk_en, i_word, i_aux_carry, i_reg_wr, i_direct_req;
  cfw_pkg::cfw_op_t i_op;
  logic [15:0]      i_a, i_b, i_res;
  logic [7:0]       i_ptr_value, i_reg_addr, i_reg_wdata, i_direct_addr, o_reg_rdata, o_work_addr, o_status_flags;
  logic [3:0]       i_work_num;
  logic             o_reg_hit, o_direct_refused, o_data_space;
  logic [7:0]       v, r;
  cfw_note_t        q[$];
  string            names[6] = '{"flags", "rdata", "work_addr", "refused", "data_space", "hit"};
  int               cyc, errors, n_checks, seed, k;

  cfw_flags_ptrs u_cfw_flags_ptrs (.i_clk, .i_resetn, .i_clk_en, .i_op, .i_word, .i_a, .i_b, .i_res,
    .i_aux_carry, .i_ptr_value, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_hit,
    .i_work_num, .i_direct_addr, .i_direct_req, .o_work_addr, .o_direct_refused, .o_status_flags,
    .o_data_space);
  cfw_exec_model u_cfw_exec_model (.i_op, .i_word, .i_a, .i_b, .o_res(i_res), .o_aux_carry(i_aux_carry));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(int kind, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", names[kind], exp, seen);
    end
  endtask

  task automatic note(int kind, logic [7:0] mask, logic [7:0] exp, int lat);
    q.push_back('{cyc + lat, kind, mask, exp});
  endtask

  task automatic drive(cfw_pkg::cfw_op_t op, logic w, logic [15:0] a, logic [15:0] b, logic [7:0] p);
    @(posedge i_clk);
    i_op        <= op;
    i_word      <= w;
    i_a         <= a;
    i_b         <= b;
    i_ptr_value <= p;
    i_reg_wr    <= 1'b0;
  endtask

  task automatic fop(cfw_pkg::cfw_op_t op, logic w, logic [15:0] a, logic [15:0] b, logic [7:0] m, logic [7:0] e);
    drive(op, w, a, b, 8'h00);
    note(0, m, e, 3);
  endtask

  task automatic acc(logic wr, logic [7:0] addr, logic [7:0] d);
    @(posedge i_clk);
    i_op        <= cfw_pkg::OP_NONE;
    i_reg_wr    <= wr;
    i_reg_addr  <= addr;
    i_reg_wdata <= d;
  endtask

  task automatic rd(logic [7:0] addr, logic [7:0] m, logic [7:0] e);
    acc(1'b0, addr, 8'h00);
    note(1, m, e, 2);
    note(5, 8'h01, {7'h00, addr inside {8'he7, 8'he8, 8'he9}}, 2);
  endtask

  task automatic wq(logic [3:0] n, logic [7:0] e);
    acc(1'b0, 8'h00, 8'h00);
    i_work_num <= n;
    note(2, 8'hff, e, 2);
  endtask

  task automatic dq(logic [7:0] addr, logic e);
    acc(1'b0, 8'h00, 8'h00);
    i_direct_req  <= 1'b1;
    i_direct_addr <= addr;
    note(3, 8'h01, {7'h00, e}, 2);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Result monitor: oldest note is due first
  always @(negedge i_clk) begin
    cyc++;
    while (q.size() > 0 && q[0].due <= cyc) begin
      case (q[0].kind)
        0: v = o_status_flags;
        1: v = o_reg_rdata;
        2: v = o_work_addr;
        3: v = {7'h00, o_direct_refused};
        4: v = {7'h00, o_data_space};
        default: v = {7'h00, o_reg_hit};
      endcase
      chk(q[0].kind, v & q[0].mask, q[0].exp & q[0].mask);
      void'(q.pop_front());
    end
  end

  initial begin
    #(3000 * 50);
    errors++;
    end_of_test();
  end

  initial begin
    seed          = 48475;
    i_resetn      = 1'b0;
    i_clk_en      = 1'b1;
    i_op          = cfw_pkg::OP_NONE;
    {i_word, i_a, i_b, i_ptr_value} = '0;
    {i_reg_wr, i_reg_addr, i_reg_wdata} = '0;
    {i_work_num, i_direct_addr, i_direct_req} = '0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (k = 0; k < 4; k++) begin
      r = 8'($random(seed));
      acc(1'b1, cfw_pkg::ADDR_STATUS_FLAGS, r);
      note(0, 8'hff, r, 3);
      rd(cfw_pkg::ADDR_STATUS_FLAGS, 8'hff, r);
    end
    acc(1'b1, cfw_pkg::ADDR_STATUS_FLAGS, 8'h00);
    fop(cfw_pkg::OP_ADD, 1'b0, 16'h007f, 16'h0001, 8'hff, 8'h34);
    fop(cfw_pkg::OP_ADD, 1'b1, 16'hffff, 16'h0001, 8'hfb, 8'hc0);
    fop(cfw_pkg::OP_SUB, 1'b0, 16'h0000, 16'h0001, 8'hff, 8'hac);
    fop(cfw_pkg::OP_SUF, 1'b0, 16'h0000, 16'h0000, 8'hff, 8'hae);
    fop(cfw_pkg::OP_LOGIC, 1'b0, 16'h000f, 16'h00f0, 8'he3, 8'hc2);
    fop(cfw_pkg::OP_SDM, 1'b0, 16'h0000, 16'h0000, 8'h03, 8'h03);
    note(4, 8'h01, 8'h01, 3);
    fop(cfw_pkg::OP_SCF, 1'b0, 16'h0000, 16'h0000, 8'h80, 8'h80);
    fop(cfw_pkg::OP_RCF, 1'b0, 16'h0000, 16'h0000, 8'h80, 8'h00);
    fop(cfw_pkg::OP_CCF, 1'b0, 16'h0000, 16'h0000, 8'h80, 8'h80);
    for (k = cfw_pkg::OP_LOGIC; k <= cfw_pkg::OP_TEST; k++)
      fop(cfw_pkg::cfw_op_t'(k), 1'b1, 16'($random(seed)), 16'($random(seed)), 8'h80, 8'h80);
    drive(cfw_pkg::OP_NONE, 1'b0, 16'h0000, 16'h0000, 8'h00);
    @(posedge i_clk);
    i_clk_en <= 1'b0;
    i_op     <= cfw_pkg::OP_RCF;
    note(0, 8'h80, 8'h80, 3);
    @(posedge i_clk);
    i_clk_en <= 1'b1;
    i_op     <= cfw_pkg::OP_NONE;
    fop(cfw_pkg::OP_SPM, 1'b0, 16'h0000, 16'h0000, 8'h01, 8'h00);
    note(4, 8'h01, 8'h00, 3);
    fop(cfw_pkg::OP_RUF, 1'b0, 16'h0000, 16'h0000, 8'h02, 8'h00);
    for (k = cfw_pkg::OP_ADC; k <= cfw_pkg::OP_MULDIV; k++)
      fop(cfw_pkg::cfw_op_t'(k), 1'b1, 16'($random(seed)), 16'($random(seed)), 8'h03, 8'h00);
    $display("test flags done");
    // Twin windows on 8 boundaries; SRP with 38 checks align-down to 30; high pointer only used as twin pointer
    drive(cfw_pkg::OP_LOAD_HIGH_WINDOW, 1'b0, 16'h0000, 16'h0000, 8'h20);
    drive(cfw_pkg::OP_LOAD_LOW_WINDOW, 1'b0, 16'h0000, 16'h0000, 8'h60);
    rd(cfw_pkg::ADDR_WORK_PTR_LOW, 8'hff, 8'h64);
    rd(cfw_pkg::ADDR_WORK_PTR_HIGH, 8'hff, 8'h24);
    wq(4'h5, 8'h65);
    wq(4'hc, 8'h24);
    drive(cfw_pkg::OP_SRP, 1'b0, 16'h0000, 16'h0000, 8'h38);
    rd(cfw_pkg::ADDR_WORK_PTR_LOW, 8'hff, 8'h30);
    rd(cfw_pkg::ADDR_WORK_PTR_HIGH, 8'h07, 8'h00);
    wq(4'h7, 8'h37);
    wq(4'hf, 8'h3f);
    drive(cfw_pkg::OP_SRP, 1'b0, 16'h0000, 16'h0000, 8'hd0);
    wq(4'h3, 8'hd3);
    acc(1'b1, cfw_pkg::ADDR_WORK_PTR_LOW, 8'hff);
    rd(cfw_pkg::ADDR_WORK_PTR_LOW, 8'hff, 8'hf8);
    rd(8'h10, 8'hff, 8'h00);
    dq(8'hd3, 1'b1);
    dq(8'hc3, 1'b0);
    dq(8'he7, 1'b0);
    $display("test pointers done");
    k = 0;
    while (q.size() > 0 && k < 20) begin
      @(posedge i_clk);
      k++;
    end
    if (q.size() > 0) errors++;
    end_of_test();
  end
endmodule // tb_cfw_flags_ptrs
